// ### src/tt_defs.svh
// constants for the thermal trip monitor
`ifndef TT_DEFS_SVH
`define TT_DEFS_SVH
`define TT_NUM_SENSORS 8
`define TT_CODE_W 9
`define TT_TRIM_W 6
`define TT_NUM_TRIPS 4
`define TT_HOT_TRIP 3
`define TT_CODE_TJMAX 9'h07F
`define TT_CODE_COOLEST 9'h0FF
`define TT_CODE_HOTTEST 9'h000
`define TT_HOT_THR_RST 9'h07F
`define TT_GEN_THR_RST 9'h000
`define TT_CLK_MHZ 100
`define TT_SETTLE_NS 200
`define TT_SETTLE_CYC ((`TT_SETTLE_NS * `TT_CLK_MHZ + 999) / 1000)
`define TT_CNT_W 8
`define TT_NUM_EVENTS 7
`define TT_ST_PHOT 4
`define TT_ST_VR_ICC 5
`define TT_ST_REGULATOR_HOT_THRESHOLD 6
`endif

// ### src/tt_pkg.sv
// types shared by the thermal trip monitor modules
package tt_pkg;
   typedef logic [8:0] tt_code_t;
   typedef logic [5:0] tt_trim_t;
   typedef logic [7:0][8:0] tt_code_arr_t;
   typedef logic [7:0][5:0] tt_trim_arr_t;
   typedef logic [3:0][8:0] tt_thr_arr_t;
   typedef logic [6:0] tt_event_t;
   typedef enum logic [1:0] {
      SENS_OFF,
      SENS_SETTLE,
      SENS_RUN
   } tt_sens_state_t;
endpackage

// ### src/tt_sensor_if.sv
// link between the monitor and one on-die sensor channel
`timescale 1ns/1ps
interface tt_sensor_if;
   import tt_pkg::*;
   logic enable;
   tt_code_t fuse_max;
   tt_code_t code;
   logic valid;
   logic trip;
   modport sensor (
      input enable,
      input fuse_max,
      output code,
      output valid,
      output trip
   );
   modport monitor (
      output enable,
      output fuse_max,
      input code,
      input valid,
      input trip
   );
endinterface

// ### src/tt_sensor_channel.sv
// one on-die sensor: sync, trim, settle, code and sticky trip
`timescale 1ns/1ps
`include "tt_defs.svh"
module tt_sensor_channel
   import tt_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire tt_code_t raw_code,
   input wire tt_trim_t trim,
   tt_sensor_if.sensor sens
);
   tt_code_t raw_meta, raw_sync, raw_hold;
   logic raw_stable;
   tt_code_t code, next_code;
   logic valid, next_valid, trip, next_trip;
   tt_sens_state_t state, next_state;
   logic [`TT_CNT_W-1:0] cnt, next_cnt;
   tt_code_t comp;

   // apply fused trim, clamp to hottest..coolest
   function automatic tt_code_t trim_clamp(input tt_code_t r, input tt_trim_t t);
      logic signed [10:0] s;
      s = $signed({2'b00, r}) + $signed({{5{t[5]}}, t});
      if (s < 0) begin
         trim_clamp = `TT_CODE_HOTTEST;
      end else if (s > $signed({2'b00, `TT_CODE_COOLEST})) begin
         trim_clamp = `TT_CODE_COOLEST;
      end else begin
         trim_clamp = s[8:0];
      end
   endfunction

   assign comp = trim_clamp(raw_sync, trim);

   // bit-wise synced counter may be caught mid-change; use it only when two samples agree
   assign raw_stable = (raw_sync == raw_hold);

   // sequencing, code and trip next values
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      case (state)
         SENS_OFF: begin
            next_cnt = '0;
            if (sens.enable) begin
               next_state = SENS_SETTLE;
            end
         end
         SENS_SETTLE: begin
            next_cnt = cnt + 8'h01;
            if (!sens.enable) begin
               next_state = SENS_OFF;
            end else if (cnt == 8'(`TT_SETTLE_CYC - 1)) begin
               next_state = SENS_RUN;
            end
         end
         SENS_RUN: begin
            if (!sens.enable) begin
               next_state = SENS_OFF;
            end
         end
         default: next_state = SENS_OFF;
      endcase
      next_valid = (state == SENS_RUN);
      // an incoherent sample keeps the last code, so a torn word cannot trip
      next_code = (state == SENS_RUN) ? (raw_stable ? comp : code) : `TT_CODE_COOLEST;
      // lower code is hotter; only a running sensor may trip
      next_trip = trip | ((state == SENS_RUN) && raw_stable && (comp <= sens.fuse_max));
   end

   // two-flop capture of the sensor counter, then state
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         raw_meta <= `TT_CODE_COOLEST;
         raw_sync <= `TT_CODE_COOLEST;
         raw_hold <= `TT_CODE_COOLEST;
         state <= SENS_OFF;
         cnt <= '0;
         code <= `TT_CODE_COOLEST;
         valid <= 1'b0;
         trip <= 1'b0;
      end else begin
         raw_meta <= raw_code;
         raw_sync <= raw_meta;
         raw_hold <= raw_sync;
         state <= next_state;
         cnt <= next_cnt;
         code <= next_code;
         valid <= next_valid;
         trip <= next_trip;
      end
   end

   assign sens.code = code;
   assign sens.valid = valid;
   assign sens.trip = trip;
endmodule // tt_sensor_channel

// ### src/tt_thermal_trip_monitor.sv
// thermal trip monitor top: sensors, shutdown, trip points, status
//
// Functional notes
// - eight sensors deliver codes continuously
// - 9-bit code, 127 is 90 C
// - code 255 is coolest, -38 C
// - codes are trimmed for process variation
// - one fused hardware trip per sensor
// - four software programmable trip thresholds
// - trip when temperature reaches fused maximum
// - trip inactive while disabled; needs PLL lock
// - trip is flopped before leaving sensor
// - trip sticky until power cycle
// - all trips combine into one shutdown
// - sensors enabled by power unit after setup
// - hot trip threshold resets preset, writable
// - three general thresholds reset to zero
// - general trip silent until enabled
// - platform hot starts enabled throttle mechanism
// - no external sensors; bits stay reserved
// - regulator limits set status, send message
// - events latched in status with actions
// - throttle and alert on exceeded limits
`timescale 1ns/1ps
`include "tt_defs.svh"
module tt_thermal_trip_monitor
   import tt_pkg::*;
(
   input wire logic clk,
   input wire logic arst_n,
   input wire tt_code_arr_t sensor_raw_code,
   input wire tt_trim_arr_t sensor_trim,
   input wire tt_code_t fuse_max_code,
   input wire logic pll_lock,
   input wire logic pmu_sensor_enable,
   input wire logic thr_wr_en,
   input wire logic [1:0] thr_wr_sel,
   input wire tt_code_t thr_wr_data,
   input wire logic [3:0] trip_enable,
   input wire tt_event_t status_clr,
   input wire tt_event_t action_throttle,
   input wire tt_event_t action_alert,
   input wire logic platform_hot_input_n,
   input wire logic tm1_enable,
   input wire logic tm2_enable,
   input wire logic regulator_current_limit,
   input wire logic regulator_hot_threshold,
   output tt_code_arr_t on_die_temp_sensor_code,
   output logic [7:0] sensor_trip,
   output logic catastrophic_shutdown,
   output logic pll_rail_shutdown,
   output tt_thr_arr_t trip_threshold,
   output tt_event_t trip_status,
   output logic throttle_tm1,
   output logic throttle_tm2,
   output logic thermal_alert,
   output logic [1:0] regulator_link_status,
   output logic regulator_status_message_valid,
   output logic [1:0] regulator_status_message,
   output logic [1:0] external_sensor_reserved
);

   // synchroniser stages for asynchronous pins
   logic lock_meta, lock_sync;
   logic phot_meta, phot_sync_n;
   logic icc_meta, icc_sync;
   logic vhot_meta, vhot_sync;

   // sensor channel links
   tt_sensor_if sens_if [`TT_NUM_SENSORS] ();
   tt_code_arr_t codes;
   logic [7:0] valids;
   logic [7:0] trips;

   // registered state and next values
   logic shut, next_shut;
   tt_thr_arr_t thr, next_thr;
   tt_event_t status, next_status;
   tt_event_t events;
   logic [3:0] hits;
   logic tm1, next_tm1, tm2, next_tm2;
   logic alert, next_alert;
   logic [1:0] link_st, next_link_st;
   logic msg_valid, next_msg_valid;
   logic [1:0] msg, next_msg;
   logic [1:0] ext_rsvd;
   logic throttle_req;
   logic sensors_on;

   // true when a running sensor is at or hotter than a threshold
   function automatic logic any_at_or_above(
      input tt_code_arr_t c,
      input logic [7:0] v,
      input tt_code_t lim
   );
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < `TT_NUM_SENSORS; i++) begin
         if (v[i] && (c[i] <= lim)) begin
            hit = 1'b1;
         end
      end
      any_at_or_above = hit;
   endfunction

   // two flops on every pin from outside the clock domain
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         lock_meta <= 1'b0;
         lock_sync <= 1'b0;
         phot_meta <= 1'b1;
         phot_sync_n <= 1'b1;
         icc_meta <= 1'b0;
         icc_sync <= 1'b0;
         vhot_meta <= 1'b0;
         vhot_sync <= 1'b0;
      end else begin
         lock_meta <= pll_lock;
         lock_sync <= lock_meta;
         phot_meta <= platform_hot_input_n;
         phot_sync_n <= phot_meta;
         icc_meta <= regulator_current_limit;
         icc_sync <= icc_meta;
         vhot_meta <= regulator_hot_threshold;
         vhot_sync <= vhot_meta;
      end
   end

   // sensors run only once the power unit allows and the PLL is locked
   assign sensors_on = pmu_sensor_enable & lock_sync;

   // eight independent sensor channels
   for (genvar g = 0; g < `TT_NUM_SENSORS; g++) begin : g_sens
      assign sens_if[g].enable = sensors_on;
      assign sens_if[g].fuse_max = fuse_max_code;
      assign codes[g] = sens_if[g].code;
      assign valids[g] = sens_if[g].valid;
      assign trips[g] = sens_if[g].trip;
      tt_sensor_channel u_chan (
         .clk(clk),
         .arst_n(arst_n),
         .raw_code(sensor_raw_code[g]),
         .trim(sensor_trim[g]),
         .sens(sens_if[g])
      );
   end

   // shutdown request: or of all sticky trips, held until power cycle
   always_comb begin
      next_shut = shut | (|trips);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         shut <= 1'b0;
      end else begin
         shut <= next_shut;
      end
   end

   // threshold registers: hot point preset, general points zero
   always_comb begin
      next_thr = thr;
      if (thr_wr_en) begin
         next_thr[thr_wr_sel] = thr_wr_data;
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         for (int t = 0; t < `TT_NUM_TRIPS; t++) begin
            thr[t] <= (t == `TT_HOT_TRIP) ? `TT_HOT_THR_RST : `TT_GEN_THR_RST;
         end
      end else begin
         thr <= next_thr;
      end
   end

   // trip point detection, each gated by its own enable
   always_comb begin
      for (int t = 0; t < `TT_NUM_TRIPS; t++) begin
         hits[t] = trip_enable[t] & any_at_or_above(codes, valids, thr[t]);
      end
   end

   // events feeding the status register
   always_comb begin
      events = '0;
      events[3:0] = hits;
      events[`TT_ST_PHOT] = ~phot_sync_n;
      events[`TT_ST_VR_ICC] = icc_sync;
      events[`TT_ST_REGULATOR_HOT_THRESHOLD] = vhot_sync;
   end

   // sticky status, write-one clear, a new event beats the clear
   always_comb begin
      next_status = (status & ~status_clr) | events;
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         status <= '0;
      end else begin
         status <= next_status;
      end
   end

   // throttle from platform hot or from events with a throttle action
   assign throttle_req = ~phot_sync_n | (|(status & action_throttle));

   // mechanisms start only if enabled; alert from events with alert action
   always_comb begin
      next_tm1 = throttle_req & tm1_enable;
      next_tm2 = throttle_req & tm2_enable;
      next_alert = |(status & action_alert);
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         tm1 <= 1'b0;
         tm2 <= 1'b0;
         alert <= 1'b0;
      end else begin
         tm1 <= next_tm1;
         tm2 <= next_tm2;
         alert <= next_alert;
      end
   end

   // regulator link status bits and a message on each new threshold hit
   always_comb begin
      next_link_st = {vhot_sync, icc_sync};
      next_msg_valid = |({vhot_sync, icc_sync} & ~link_st);
      next_msg = msg;
      if (next_msg_valid) begin
         next_msg = {vhot_sync, icc_sync};
      end
   end

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         link_st <= 2'h0;
         msg_valid <= 1'b0;
         msg <= 2'h0;
      end else begin
         link_st <= next_link_st;
         msg_valid <= next_msg_valid;
         msg <= next_msg;
      end
   end

   // reserved external sensor bits: no external sensor path exists
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         ext_rsvd <= 2'h0;
      end else begin
         ext_rsvd <= 2'h0;
      end
   end

   // outputs, all from flops
   assign on_die_temp_sensor_code = codes;
   assign sensor_trip = trips;
   assign catastrophic_shutdown = shut;
   assign pll_rail_shutdown = shut;
   assign trip_threshold = thr;
   assign trip_status = status;
   assign throttle_tm1 = tm1;
   assign throttle_tm2 = tm2;
   assign thermal_alert = alert;
   assign regulator_link_status = link_st;
   assign regulator_status_message_valid = msg_valid;
   assign regulator_status_message = msg;
   assign external_sensor_reserved = ext_rsvd;

endmodule // tt_thermal_trip_monitor

// ### testbench/tt_trip_check_monitor.sv
// assertions on the thermal trip monitor ports
`timescale 1ns/1ps
module tt_trip_check
   import tt_pkg::*;
(
   input logic clk,
   input logic arst_n,
   input logic pll_lock,
   input logic pmu_sensor_enable,
   input logic thr_wr_en,
   input logic [1:0] thr_wr_sel,
   input tt_code_t thr_wr_data,
   input logic [3:0] trip_enable,
   input tt_event_t status_clr,
   input logic platform_hot_input_n,
   input logic tm1_enable,
   input logic [7:0] sensor_trip,
   input logic catastrophic_shutdown,
   input tt_thr_arr_t trip_threshold,
   input tt_event_t trip_status,
   input logic throttle_tm1
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // any sensor trip shuts down next cycle, and trips never drop
   a_trip_shutdown: assert property (sensor_trip != 8'h00 |=> catastrophic_shutdown)
      else $error("shutdown late");
   a_trip_sticky: assert property (((~sensor_trip) & $past(sensor_trip)) == 8'h00)
      else $error("sensor trip dropped");
   a_trip_gated: assert property (
      $changed(sensor_trip) |-> $past(pll_lock, 5) && $past(pmu_sensor_enable, 5))
      else $error("trip while sensors off");
   // thresholds leave reset preset and take writes one cycle later
   a_thr_preset: assert property ($rose(arst_n) |->
      trip_threshold == {9'h07F, 9'h000, 9'h000, 9'h000})
      else $error("threshold reset value");
   a_thr_write: assert property (thr_wr_en |=>
      trip_threshold[$past(thr_wr_sel)] == $past(thr_wr_data))
      else $error("threshold write lost");
   // trip point status rises only when enabled, and status falls only on a clear
   a_trip_enable: assert property (
      (trip_status[3:0] & ~$past(trip_status[3:0]) & ~$past(trip_enable)) == 4'h0)
      else $error("disabled trip point fired");
   a_status_hold: assert property (
      ((~trip_status) & $past(trip_status) & ~$past(status_clr)) == 7'h00)
      else $error("status dropped");
   // a held platform hot throttles through mechanism one
   a_hot_throttle: assert property (
      (!platform_hot_input_n && tm1_enable) [*5] |=> throttle_tm1)
      else $error("no throttle");
endmodule // tt_trip_check

bind tt_thermal_trip_monitor tt_trip_check u_chk (.clk(clk), .arst_n(arst_n),
   .pll_lock(pll_lock), .pmu_sensor_enable(pmu_sensor_enable), .thr_wr_en(thr_wr_en),
   .thr_wr_sel(thr_wr_sel), .thr_wr_data(thr_wr_data), .trip_enable(trip_enable),
   .status_clr(status_clr), .platform_hot_input_n(platform_hot_input_n),
   .tm1_enable(tm1_enable), .sensor_trip(sensor_trip),
   .catastrophic_shutdown(catastrophic_shutdown), .trip_threshold(trip_threshold),
   .trip_status(trip_status), .throttle_tm1(throttle_tm1));

// ### testbench/tt_platform_model.sv
// far side model: raw counters of the eight sensors
`timescale 1ns/1ps
module tt_platform_model
   import tt_pkg::*;
(
   input logic clk,
   input logic load,
   input logic [2:0] idx,
   input tt_code_t code,
   output tt_code_arr_t raw
);
   initial raw = {8{9'h0C8}};
   // one counter moves just after an edge, as a live sensor would
   always @(posedge clk) begin
      if (load) begin
         raw[idx] <= code;
      end
   end
endmodule // tt_platform_model

// ### testbench/tb.sv
// self-checking bench for the thermal trip monitor
`timescale 1ns/1ps
module tb;
   import tt_pkg::*;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   tt_trim_arr_t trim = {6'h3E, 42'h0};
   tt_code_t fuse = 9'h050;
   logic lock = 1'b0;
   logic sen = 1'b0;
   logic wr_en = 1'b0;
   logic [1:0] wr_sel = 2'h0;
   tt_code_t wr_data = 9'h000;
   logic [3:0] t_en = 4'h0;
   tt_event_t clr = 7'h00;
   tt_event_t act_thr = 7'h00;
   tt_event_t act_alr = 7'h00;
   logic hot_n = 1'b1;
   logic [1:0] tm = 2'h0;
   logic icc = 1'b0;
   logic vhot = 1'b0;
   logic m_load = 1'b0;
   logic [2:0] m_idx = 3'h0;
   tt_code_t m_code = 9'h000;
   tt_thr_arr_t tv = {9'h080, 9'h0C8, 9'h078, 9'h082};
   tt_code_arr_t raw, code;
   tt_thr_arr_t thr;
   tt_event_t st;
   logic [7:0] strip;
   logic stop, rail, t1, t2, alert, mv;
   logic [1:0] lnk, msg, ext;
   int num_errors = 0;
   int n_compared = 0;

   // clock
   always #5 clk = ~clk;

   tt_platform_model u_plat (.clk(clk), .load(m_load), .idx(m_idx), .code(m_code), .raw(raw));
   tt_thermal_trip_monitor u_dut (.clk(clk), .arst_n(arst_n), .sensor_raw_code(raw),
      .sensor_trim(trim), .fuse_max_code(fuse), .pll_lock(lock), .pmu_sensor_enable(sen),
      .thr_wr_en(wr_en), .thr_wr_sel(wr_sel), .thr_wr_data(wr_data), .trip_enable(t_en),
      .status_clr(clr), .action_throttle(act_thr), .action_alert(act_alr),
      .platform_hot_input_n(hot_n), .tm1_enable(tm[0]), .tm2_enable(tm[1]),
      .regulator_current_limit(icc), .regulator_hot_threshold(vhot),
      .on_die_temp_sensor_code(code), .sensor_trip(strip), .catastrophic_shutdown(stop),
      .pll_rail_shutdown(rail), .trip_threshold(thr), .trip_status(st), .throttle_tm1(t1),
      .throttle_tm2(t2), .thermal_alert(alert), .regulator_link_status(lnk),
      .regulator_status_message_valid(mv), .regulator_status_message(msg),
      .external_sensor_reserved(ext));

   // compare one value
   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // wait n edges, then let outputs settle
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   // one-cycle threshold write strobe
   task automatic wr_thr(input logic [1:0] s, input tt_code_t d);
      @(posedge clk);
      wr_en <= 1'b1;
      wr_sel <= s;
      wr_data <= d;
      @(posedge clk);
      wr_en <= 1'b0;
   endtask
   // move one sensor counter in the far side model
   task automatic set_raw(input logic [2:0] i, input tt_code_t c);
      @(posedge clk);
      m_load <= 1'b1;
      m_idx <= i;
      m_code <= c;
      @(posedge clk);
      m_load <= 1'b0;
   endtask
   task automatic done(input string nm);
      $display("test %s finished", nm);
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   // test sequence
   initial begin
      repeat (8) @(posedge clk);
      arst_n <= 1'b1;
      cyc(1);
      for (int i = 0; i < 8; i++) begin
         chk("code", code[i], 9'h0FF);
      end
      for (int i = 0; i < 3; i++) begin
         chk("gen_thr", thr[i], 9'h000);
      end
      chk("hot_thr", thr[3], 9'h07F);
      chk("reserved", ext, 2'h0);
      done("reset");
      for (int i = 0; i < 4; i++) begin
         wr_thr(2'(i), tv[i]);
      end
      t_en <= 4'hB;
      cyc(1);
      for (int i = 0; i < 4; i++) begin
         chk("thr", thr[i], tv[i]);
      end
      @(posedge clk);
      lock <= 1'b1;
      sen <= 1'b1;
      cyc(30);
      for (int i = 0; i < 8; i++) begin
         chk("run_code", code[i], (i == 7) ? 9'h0C6 : 9'h0C8);
      end
      chk("idle_pts", st[3:0], 4'h0);
      set_raw(3'h5, 9'h078);
      cyc(5);
      chk("code5", code[5], 9'h078);
      chk("trip_pts", st[3:0], 4'hB);
      set_raw(3'h5, 9'h0C8);
      cyc(5);
      chk("sticky", st[3:0], 4'hB);
      @(posedge clk);
      clr <= 7'h01;
      @(posedge clk);
      clr <= 7'h00;
      cyc(2);
      chk("cleared", st[3:0], 4'hA);
      done("trip_points");
      @(posedge clk);
      hot_n <= 1'b0;
      act_alr <= 7'h10;
      for (int k = 1; k < 4; k++) begin
         @(posedge clk);
         tm <= 2'(k % 3);
         cyc(6);
         chk("tm1", t1, k == 1);
         chk("tm2", t2, k == 2);
      end
      chk("hot_st", st[4], 1'b1);
      chk("alert", alert, 1'b1);
      done("platform_hot");
      @(posedge clk);
      icc <= 1'b1;
      for (int w = 0; w < 10 && mv !== 1'b1; w++) begin
         cyc(1);
      end
      chk("msg_valid", mv, 1'b1);
      chk("msg", msg, 2'h1);
      cyc(1);
      chk("link", lnk, 2'h1);
      chk("icc_st", st[5], 1'b1);
      done("regulator");
      set_raw(3'h2, 9'h050);
      cyc(6);
      chk("trip", strip, 8'h04);
      chk("stop", stop, 1'b1);
      chk("rails", rail, 1'b1);
      set_raw(3'h2, 9'h0C8);
      sen <= 1'b0;
      cyc(6);
      chk("held", strip, 8'h04);
      chk("held_stop", stop, 1'b1);
      chk("off_code", code[2], 9'h0FF);
      done("catastrophic");
      @(posedge clk);
      arst_n <= 1'b0;
      cyc(2);
      @(posedge clk);
      arst_n <= 1'b1;
      set_raw(3'h2, 9'h000);
      cyc(40);
      chk("off_trip", strip, 8'h00);
      @(posedge clk);
      lock <= 1'b0;
      sen <= 1'b1;
      cyc(40);
      chk("no_lock", strip, 8'h00);
      chk("no_stop", stop, 1'b0);
      @(posedge clk);
      lock <= 1'b1;
      cyc(40);
      chk("relock", strip, 8'h04);
      done("enable");
      print_verdict();
   end

   // watchdog against a hung run
   initial begin
      repeat (3000) @(posedge clk);
      num_errors++;
      print_verdict();
   end
endmodule // tb
